/* File: ccr_pkg.sv */
/*
 * Shared constants and types for the capture/compare/PWM timer routing block.
 * Assumes a single 100 MHz core clock and an active-low asynchronous reset.
 */
package ccr_pkg;

    // Core clock period in nanoseconds.
    localparam int CCR_CLK_PERIOD_NS = 10;

    // Register select: bit 2 picks the unit, bits 1:0 pick the register.
    localparam logic [1:0] CCR_SEL_CONTROL = 2'h0;
    localparam logic [1:0] CCR_SEL_LOW = 2'h1;
    localparam logic [1:0] CCR_SEL_HIGH = 2'h2;
    localparam int CCR_SEL_UNIT_BIT = 2;

    // Reset value of every unit register.
    localparam logic [7:0] CCR_REG_RESET = 8'h00;

    // Field position of the mode nibble in the unit control register.
    localparam int CCR_MODE_MSB = 3;
    localparam int CCR_MODE_LSB = 0;

    // Timer-to-unit select bits from the timer-three control register.
    localparam int CCR_T3SEL_BOTH_BIT = 1;
    localparam int CCR_T3SEL_TWO_BIT = 0;

    // Mode codes held in the mode nibble.
    localparam logic [3:0] CCR_MODE_OFF = 4'h0;
    localparam logic [3:0] CCR_MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] CCR_MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] CCR_MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] CCR_MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] CCR_MODE_CMP_SET = 4'h8;
    localparam logic [3:0] CCR_MODE_CMP_CLR = 4'h9;
    localparam logic [3:0] CCR_MODE_CMP_FLAG = 4'ha;
    localparam logic [3:0] CCR_MODE_CMP_TRIG = 4'hb;

    // Capture prescaler terminal counts (events minus one).
    localparam logic [3:0] CCR_PRESCALE_4 = 4'h3;
    localparam logic [3:0] CCR_PRESCALE_16 = 4'hf;

    // Capture edge kinds; values equal the low two mode bits.
    typedef enum logic [1:0] {
        CCR_EDGE_FALL = 2'h0,
        CCR_EDGE_RISE = 2'h1,
        CCR_EDGE_RISE4 = 2'h2,
        CCR_EDGE_RISE16 = 2'h3
    } ccr_edge_e;

    // Register set of one unit as software sees it.
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] data_high;
        logic [7:0] data_low;
    } ccr_unit_regs_s;

endpackage : ccr_pkg

/* File: ccr_capture_edge.sv */
/*
 * Capture event detector for one unit: edge selection and prescaling.
 * Assumes the pin input is already synchronous to core_clk.
 */
`timescale 1ns/1ps
module ccr_capture_edge (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire ccr_pkg::ccr_edge_e edge_kind,
    input wire logic pin_in,
    output logic capture_pulse
);

    // Previous pin sample and prescaler count.
    logic pin_reg;
    logic pin_next;
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic pulse_reg;
    logic pulse_next;

    // Detect the chosen edge and count it up through the prescaler.
    always_comb
    begin
        logic rise;
        logic fall;
        rise = pin_in & ~pin_reg;
        fall = ~pin_in & pin_reg;
        pin_next = pin_in;
        count_next = count_reg;
        pulse_next = 1'b0;
        if (!enable)
        begin
            // A disabled unit restarts its prescaler from zero.
            count_next = 4'h0;
        end
        else
        begin
            case (edge_kind)
                ccr_pkg::CCR_EDGE_FALL: pulse_next = fall;
                ccr_pkg::CCR_EDGE_RISE: pulse_next = rise;
                ccr_pkg::CCR_EDGE_RISE4, ccr_pkg::CCR_EDGE_RISE16:
                begin
                    if (rise)
                    begin
                        if ((edge_kind == ccr_pkg::CCR_EDGE_RISE4 &&
                             count_reg == ccr_pkg::CCR_PRESCALE_4) ||
                            count_reg == ccr_pkg::CCR_PRESCALE_16)
                        begin
                            pulse_next = 1'b1;
                            count_next = 4'h0;
                        end
                        else
                        begin
                            count_next = count_reg + 4'h1;
                        end
                    end
                end
                default: pulse_next = 1'b0;
            endcase
        end
    end

    // Register the detector state.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_reg <= 1'b0;
            count_reg <= 4'h0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            pin_reg <= pin_next;
            count_reg <= count_next;
            pulse_reg <= pulse_next;
        end
    end

    assign capture_pulse = pulse_reg;

endmodule : ccr_capture_edge

/* File: ccr_pwm_out.sv */
/*
 * PWM output stage for one unit, timed by timer two.
 * Assumes timer_two_period pulses once per timer-two period.
 */
`timescale 1ns/1ps
module ccr_pwm_out (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic [7:0] duty_in,
    input wire logic [7:0] timer_two_count,
    input wire logic timer_two_period,
    output logic pwm_level,
    output logic [7:0] duty_active
);

    // Output level and the duty value latched for the running period.
    logic level_reg;
    logic level_next;
    logic [7:0] duty_reg;
    logic [7:0] duty_next;

    // New duty takes effect only at a period boundary, so a write never
    // produces a glitched cycle.
    always_comb
    begin
        level_next = level_reg;
        duty_next = duty_reg;
        if (!enable)
        begin
            level_next = 1'b0;
        end
        else if (timer_two_period)
        begin
            duty_next = duty_in;
            level_next = (duty_in != 8'h00);
        end
        else if (timer_two_count == duty_reg)
        begin
            level_next = 1'b0;
        end
    end

    // Register the output stage.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            level_reg <= 1'b0;
            duty_reg <= 8'h00;
        end
        else
        begin
            level_reg <= level_next;
            duty_reg <= duty_next;
        end
    end

    assign pwm_level = level_reg;
    assign duty_active = duty_reg;

endmodule : ccr_pwm_out

/* File: ccr_timer_routing.sv */
/*
 * Two capture/compare/PWM units with their timer and pin routing.
 * Assumes timers one, two and three live outside and present their counts
 * synchronous to core_clk; the timer reset and conversion start outputs
 * are one-cycle pulses consumed by those blocks.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - Each unit: readable writable control, data low, high.
// - Capture and compare use timer one or three.
// - PWM modes always run from timer two.
// - Timer-three control select bits pick each time base.
// - Both units run together, may share a timer.
// - No capture on timer one while it counts asynchronously.
// - Unit two pin: select 1 port C, 0 port B.
// - Compare trigger resets the unit's own time base.
// - Unit two trigger also starts a conversion.
// - Capturing units: only unit two may move alone to timer three.
// - Two PWM units share timer two period.
module ccr_timer_routing (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic [2:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    output ccr_pkg::ccr_unit_regs_s unit_one_regs,
    output ccr_pkg::ccr_unit_regs_s unit_two_regs,
    input wire logic [1:0] timer_three_select,
    input wire logic [15:0] timer_one_count,
    input wire logic [15:0] timer_three_count,
    input wire logic [7:0] timer_two_count,
    input wire logic timer_two_period,
    input wire logic timer_one_async,
    input wire logic unit_two_pin_select,
    input wire logic unit_one_in,
    input wire logic port_c_line_one_in,
    input wire logic port_b_line_three_in,
    output logic unit_one_out,
    output logic port_c_line_one_out,
    output logic port_c_line_one_use,
    output logic port_b_line_three_out,
    output logic port_b_line_three_use,
    output logic timer_one_reset,
    output logic timer_three_reset,
    output logic adc_start,
    output logic [1:0] unit_event
);

    // Register sets of both units, index 0 is unit one.
    ccr_pkg::ccr_unit_regs_s regs_reg [2];
    ccr_pkg::ccr_unit_regs_s regs_next [2];

    // Compare output latches and previous-cycle match flags.
    logic [1:0] cmp_reg;
    logic [1:0] cmp_next;
    logic [1:0] match_reg;
    logic [1:0] match_next;

    // Registered pulses towards timers, converter and event watchers.
    logic t1_reset_reg;
    logic t1_reset_next;
    logic t3_reset_reg;
    logic t3_reset_next;
    logic adc_reg;
    logic adc_next;
    logic [1:0] event_reg;
    logic [1:0] event_next;

    // Per-unit decoded view.
    logic [1:0] uses_t3;
    logic [1:0] is_capture;
    logic [1:0] is_compare;
    logic [1:0] is_pwm;
    logic [1:0] cap_pulse;
    logic [1:0] pwm_level;
    logic [1:0] cap_pin;
    ccr_pkg::ccr_edge_e edge_kind [2];

    // Unit two's capture input comes from whichever pin is selected.
    assign cap_pin[0] = unit_one_in;
    assign cap_pin[1] = unit_two_pin_select ? port_c_line_one_in
                                            : port_b_line_three_in;

    // Unit one reads only the both bit, unit two either bit, so two capturing units
    // sit on different timers only with unit one on timer one and unit two on timer three.
    assign uses_t3[0] = timer_three_select[ccr_pkg::CCR_T3SEL_BOTH_BIT];
    assign uses_t3[1] = timer_three_select[ccr_pkg::CCR_T3SEL_BOTH_BIT] |
                        timer_three_select[ccr_pkg::CCR_T3SEL_TWO_BIT];

    // Mode decode and the per-unit capture and PWM stages.
    for (genvar u = 0; u < 2; u++)
    begin : g_unit
        logic [3:0] mode;
        assign mode = regs_reg[u].control[ccr_pkg::CCR_MODE_MSB:ccr_pkg::CCR_MODE_LSB];
        assign is_capture[u] = (mode[3:2] == 2'h1);
        assign is_compare[u] = (mode[3:2] == 2'h2);
        // Both the standard and enhanced PWM codes land here.
        assign is_pwm[u] = (mode[3:2] == 2'h3);
        assign edge_kind[u] = ccr_pkg::ccr_edge_e'(mode[1:0]);

        // Capture event detector.
        ccr_capture_edge u_capture (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .enable(is_capture[u]),
            .edge_kind(edge_kind[u]),
            .pin_in(cap_pin[u]),
            .capture_pulse(cap_pulse[u])
        );

        // PWM stage; both units take the same timer-two signals, so they
        // necessarily share frequency and update instant.
        ccr_pwm_out u_pwm (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .enable(is_pwm[u]),
            .duty_in(regs_reg[u].data_low),
            .timer_two_count(timer_two_count),
            .timer_two_period(timer_two_period),
            .pwm_level(pwm_level[u]),
            .duty_active()
        );
    end

    // Next-state logic for registers, compare latches and pulses.
    always_comb
    begin
        logic [3:0] mode;
        logic [15:0] base;
        logic [15:0] pair;
        logic hit;
        logic sw_hit;
        mode = 4'h0;
        base = 16'h0000;
        pair = 16'h0000;
        hit = 1'b0;
        sw_hit = 1'b0;
        regs_next = regs_reg;
        cmp_next = cmp_reg;
        match_next = 2'h0;
        t1_reset_next = 1'b0;
        t3_reset_next = 1'b0;
        adc_next = 1'b0;
        event_next = 2'h0;
        for (int u = 0; u < 2; u++)
        begin
            mode = regs_reg[u].control[ccr_pkg::CCR_MODE_MSB:ccr_pkg::CCR_MODE_LSB];
            // Capture and compare never see timer two here.
            base = uses_t3[u] ? timer_three_count : timer_one_count;
            pair = {regs_reg[u].data_high, regs_reg[u].data_low};
            sw_hit = reg_wr && (reg_sel[ccr_pkg::CCR_SEL_UNIT_BIT] == u[0]);

            // Software writes land first; hardware below may override.
            if (sw_hit)
            begin
                case (reg_sel[1:0])
                    ccr_pkg::CCR_SEL_CONTROL:
                    begin
                        regs_next[u].control = reg_wdata;
                        // Entering set mode starts low, clear mode starts high.
                        cmp_next[u] = (reg_wdata[ccr_pkg::CCR_MODE_MSB:ccr_pkg::CCR_MODE_LSB]
                                       == ccr_pkg::CCR_MODE_CMP_CLR);
                    end
                    ccr_pkg::CCR_SEL_LOW: regs_next[u].data_low = reg_wdata;
                    ccr_pkg::CCR_SEL_HIGH: regs_next[u].data_high = reg_wdata;
                    default: regs_next[u] = regs_next[u];
                endcase
            end

            // Capture: a capture in the same cycle as a data write wins,
            // so a timestamp is never lost. Timer one in asynchronous
            // counter mode has no stable count to sample, so capture is
            // suppressed on that time base.
            if (is_capture[u] && cap_pulse[u] && (uses_t3[u] || !timer_one_async))
            begin
                regs_next[u].data_high = base[15:8];
                regs_next[u].data_low = base[7:0];
                event_next[u] = 1'b1;
            end

            // Compare: act once when the count first equals the data pair.
            // If both units compare on one time base, a trigger from either
            // resets it for both; that is left to software to avoid.
            hit = is_compare[u] && (base == pair);
            match_next[u] = hit;
            if (hit && !match_reg[u])
            begin
                event_next[u] = 1'b1;
                case (mode)
                    ccr_pkg::CCR_MODE_CMP_SET: cmp_next[u] = 1'b1;
                    ccr_pkg::CCR_MODE_CMP_CLR: cmp_next[u] = 1'b0;
                    ccr_pkg::CCR_MODE_CMP_TRIG:
                    begin
                        // Only the unit's own time base is reset.
                        if (uses_t3[u])
                        begin
                            t3_reset_next = 1'b1;
                        end
                        else
                        begin
                            t1_reset_next = 1'b1;
                        end
                        // Only unit two may launch a conversion.
                        if (u == 1)
                        begin
                            adc_next = 1'b1;
                        end
                    end
                    default: cmp_next[u] = cmp_next[u];
                endcase
            end
        end
    end

    // Register everything computed above; the units are fully independent
    // apart from the shared timer inputs.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int u = 0; u < 2; u++)
            begin
                regs_reg[u] <= '{ccr_pkg::CCR_REG_RESET, ccr_pkg::CCR_REG_RESET,
                                 ccr_pkg::CCR_REG_RESET};
            end
            cmp_reg <= 2'h0;
            match_reg <= 2'h0;
            t1_reset_reg <= 1'b0;
            t3_reset_reg <= 1'b0;
            adc_reg <= 1'b0;
            event_reg <= 2'h0;
        end
        else
        begin
            regs_reg <= regs_next;
            cmp_reg <= cmp_next;
            match_reg <= match_next;
            t1_reset_reg <= t1_reset_next;
            t3_reset_reg <= t3_reset_next;
            adc_reg <= adc_next;
            event_reg <= event_next;
        end
    end

    // Register read-back and pulse outputs.
    assign unit_one_regs = regs_reg[0];
    assign unit_two_regs = regs_reg[1];
    assign timer_one_reset = t1_reset_reg;
    assign timer_three_reset = t3_reset_reg;
    assign adc_start = adc_reg;
    assign unit_event = event_reg;

    // Output levels: PWM level in PWM mode, compare latch otherwise.
    // The use flags only claim the pin function; the pin direction register
    // stays untouched and software must set it for either pin.
    assign unit_one_out = is_pwm[0] ? pwm_level[0] : cmp_reg[0];
    assign port_c_line_one_out = is_pwm[1] ? pwm_level[1] : cmp_reg[1];
    assign port_b_line_three_out = is_pwm[1] ? pwm_level[1] : cmp_reg[1];
    assign port_c_line_one_use = unit_two_pin_select &&
                                 (is_pwm[1] || is_compare[1]);
    assign port_b_line_three_use = !unit_two_pin_select &&
                                   (is_pwm[1] || is_compare[1]);

endmodule : ccr_timer_routing

/* File: ccr_timer_model.sv */
/* Timer model for the far side of the routing block: timers one, two and three.
   Assumes one core clock; timer one and three counts move only while run is high, so captures are predictable. */
`timescale 1ns/1ps
module ccr_timer_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic timer_one_reset,
    input wire logic timer_three_reset,
    output logic [15:0] timer_one_count,
    output logic [15:0] timer_three_count,
    output logic [7:0] timer_two_count,
    output logic timer_two_period
);
    logic [15:0] t1_reg; // Timer one count.
    logic [15:0] t1_next;
    logic [15:0] t3_reg; // Timer three count.
    logic [15:0] t3_next;
    logic [7:0] t2_reg; // Timer two runs free so PWM always has a base.
    logic [7:0] t2_next;

    // A trigger reset wins over counting, as a real timer would behave.
    always_comb
    begin
        t1_next = timer_one_reset ? 16'h0000 : t1_reg + {15'h0000, run};
        t3_next = timer_three_reset ? 16'h0000 : t3_reg + {15'h0000, run};
        t2_next = (t2_reg == 8'h0f) ? 8'h00 : t2_reg + 8'h01;
    end

    // Distinct start values let the bench tell which timer was captured.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            t1_reg <= 16'h1000;
            t3_reg <= 16'h3000;
            t2_reg <= 8'h00;
        end
        else
        begin
            t1_reg <= t1_next;
            t3_reg <= t3_next;
            t2_reg <= t2_next;
        end
    end

    assign timer_one_count = t1_reg;
    assign timer_three_count = t3_reg;
    assign timer_two_count = t2_reg;
    assign timer_two_period = (t2_reg == 8'h0f); // One cycle per period.
endmodule : ccr_timer_model

/* File: ccr_monitor.sv */
/* Port checker for the capture/compare/PWM routing block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module ccr_monitor (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire ccr_pkg::ccr_unit_regs_s unit_one_regs,
    input wire ccr_pkg::ccr_unit_regs_s unit_two_regs,
    input wire logic [1:0] timer_three_select,
    input wire logic timer_one_async,
    input wire logic unit_two_pin_select,
    input wire logic timer_two_period,
    input wire logic unit_one_out,
    input wire logic port_c_line_one_use,
    input wire logic port_b_line_three_use,
    input wire logic timer_one_reset,
    input wire logic timer_three_reset,
    input wire logic adc_start,
    input wire logic [1:0] unit_event
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [3:0] m1; // Mode nibble of unit one.
    logic [3:0] m2; // Mode nibble of unit two.
    assign m1 = unit_one_regs.control[3:0];
    assign m2 = unit_two_regs.control[3:0];

    pin_c_use_a: assert property (port_c_line_one_use == (unit_two_pin_select && m2 >= 4'h8))
        else $error("port C use does not follow select");
    pin_b_use_a: assert property (port_b_line_three_use == (!unit_two_pin_select && m2 >= 4'h8))
        else $error("port B use does not follow select");
    adc_source_a: assert property (adc_start |-> $past(m2) == 4'hb)
        else $error("conversion start without unit two trigger");
    adc_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("conversion start longer than one cycle");
    t1_reset_a: assert property (timer_one_reset |->
        ($past(m1) == 4'hb && !$past(timer_three_select[1]))
        || ($past(m2) == 4'hb && $past(timer_three_select) == 2'h0))
        else $error("timer one reset without its trigger");
    t3_reset_a: assert property (timer_three_reset |->
        ($past(m1) == 4'hb && $past(timer_three_select[1]))
        || ($past(m2) == 4'hb && $past(timer_three_select) != 2'h0))
        else $error("timer three reset without its trigger");
    async_block_a: assert property ((m1 >= 4'h4 && m1 <= 4'h7 && $past(m1, 2) == m1
        && timer_three_select == 2'h0 && $past(timer_three_select, 2) == 2'h0
        && timer_one_async && $past(timer_one_async) && $past(timer_one_async, 2))
        |-> !unit_event[0])
        else $error("capture on asynchronous timer one");
    pwm_start_a: assert property ((timer_two_period && m1 >= 4'hc
        && unit_one_regs.data_low != 8'h00) |=> unit_one_out)
        else $error("PWM did not start at timer two period");
endmodule : ccr_monitor

/* File: tb.sv */
/* Self-checking bench for the capture/compare/PWM routing block.
   Assumes the timer model on the far side and the bound port checker. */
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_wr = 1'b0;
    logic [2:0] reg_sel = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [1:0] timer_three_select = 2'h0;
    logic timer_one_async = 1'b0;
    logic unit_two_pin_select = 1'b1;
    logic unit_one_in = 1'b0;
    logic port_c_line_one_in = 1'b0;
    logic port_b_line_three_in = 1'b0;
    logic run = 1'b0; // Timers one and three stand still unless a scenario needs them moving.
    ccr_pkg::ccr_unit_regs_s unit_one_regs;
    ccr_pkg::ccr_unit_regs_s unit_two_regs;
    logic [15:0] timer_one_count;
    logic [15:0] timer_three_count;
    logic [7:0] timer_two_count;
    logic timer_two_period;
    logic unit_one_out;
    logic port_c_line_one_out;
    logic port_c_line_one_use;
    logic port_b_line_three_out;
    logic port_b_line_three_use;
    logic timer_one_reset;
    logic timer_three_reset;
    logic adc_start;
    logic [1:0] unit_event;
    logic [1:0] ev_seen = 2'h0; // Sticky record of event pulses.
    logic ev_clr = 1'b0; // Empties the record at the next edge.
    int n_mismatch = 0;
    int n_compared = 0;

    ccr_timer_routing dut_u (.core_clk, .reset_n, .reg_wr, .reg_sel, .reg_wdata,
        .unit_one_regs, .unit_two_regs, .timer_three_select, .timer_one_count,
        .timer_three_count, .timer_two_count, .timer_two_period, .timer_one_async,
        .unit_two_pin_select, .unit_one_in, .port_c_line_one_in, .port_b_line_three_in,
        .unit_one_out, .port_c_line_one_out, .port_c_line_one_use, .port_b_line_three_out,
        .port_b_line_three_use, .timer_one_reset, .timer_three_reset, .adc_start, .unit_event);
    ccr_timer_model tmr_u (.core_clk, .reset_n, .run, .timer_one_reset, .timer_three_reset,
        .timer_one_count, .timer_three_count, .timer_two_count, .timer_two_period);

    always #5 core_clk = ~core_clk;

    // Event pulses last one cycle, so they are latched for later judgement.
    always @(posedge core_clk)
        ev_seen <= (ev_clr ? 2'h0 : ev_seen) | unit_event;

    task automatic clear_ev();
        ev_clr = 1'b1;
        @(negedge core_clk);
        ev_clr = 1'b0;
    endtask : clear_ev

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One write strobe, then an idle edge so strobes never meet in one step.
    task automatic wr(input logic [2:0] sel, input logic [7:0] data);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_sel = sel;
        reg_wdata = data;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic t_regs();
        wr(3'h1, 8'h34);
        wr(3'h2, 8'h12);
        wr(3'h5, 8'h78);
        wr(3'h6, 8'h56);
        wr(3'h3, 8'hff); // Unused select codes must not disturb anything.
        wr(3'h7, 8'hff);
        check("u1 pair", {unit_one_regs.data_high, unit_one_regs.data_low}, 16'h1234);
        check("u2 pair", {unit_two_regs.data_high, unit_two_regs.data_low}, 16'h5678);
        check("controls", {unit_one_regs.control, unit_two_regs.control}, 16'h0000);
    endtask : t_regs

    // Rising then falling captures under two timer selections.
    task automatic t_capture();
        wr(3'h0, 8'h05);
        wr(3'h4, 8'h05);
        timer_three_select = 2'h1;
        clear_ev();
        unit_one_in = 1'b1;
        port_c_line_one_in = 1'b1;
        repeat (6) @(negedge core_clk);
        check("cap events", {14'h0000, ev_seen}, 16'h0003);
        check("u1 cap", {unit_one_regs.data_high, unit_one_regs.data_low}, 16'h1000);
        check("u2 cap", {unit_two_regs.data_high, unit_two_regs.data_low}, 16'h3000);
        timer_three_select = 2'h2;
        wr(3'h0, 8'h04);
        wr(3'h4, 8'h04);
        clear_ev();
        unit_one_in = 1'b0;
        port_c_line_one_in = 1'b0;
        repeat (6) @(negedge core_clk);
        check("u1 cap t3", {unit_one_regs.data_high, unit_one_regs.data_low}, 16'h3000);
        check("u2 cap t3", {unit_two_regs.data_high, unit_two_regs.data_low}, 16'h3000);
        check("fall events", {14'h0000, ev_seen}, 16'h0003);
    endtask : t_capture

    task automatic t_async();
        timer_one_async = 1'b1;
        timer_three_select = 2'h0;
        wr(3'h0, 8'h05);
        clear_ev();
        unit_one_in = 1'b1;
        repeat (6) @(negedge core_clk);
        check("async event", {15'h0000, ev_seen[0]}, 16'h0000);
        timer_one_async = 1'b0;
        // Only every fourth rise may capture.
        wr(3'h0, 8'h06);
        clear_ev();
        for (int i = 2; i <= 9; i++)
        begin
            unit_one_in = i[0];
            repeat (3) @(negedge core_clk);
            if (i == 8)
                check("prescale 3", {15'h0000, ev_seen[0]}, 16'h0000);
        end
        check("prescale 4", {15'h0000, ev_seen[0]}, 16'h0001);
    endtask : t_async

    // Only unit two compares, so no second unit compares on the reset time base.
    task automatic t_compare();
        wr(3'h6, 8'h10);
        wr(3'h5, 8'h05);
        wr(3'h4, 8'h0b);
        run = 1'b1;
        for (int i = 0; i < 30 && timer_one_reset !== 1'b1; i++)
            @(negedge core_clk);
        check("t1 reset", {15'h0000, timer_one_reset}, 16'h0001);
        check("adc start", {15'h0000, adc_start}, 16'h0001);
        check("cmp event", {15'h0000, unit_event[1]}, 16'h0001);
        check("t3 reset", {15'h0000, timer_three_reset}, 16'h0000);
        @(negedge core_clk);
        run = 1'b0;
        check("t1 cleared", timer_one_count, 16'h0000);
    endtask : t_compare

    // Pin direction is left to software; only the use flags and pin outputs are judged here.
    task automatic t_pins();
        check("c use", {14'h0000, port_c_line_one_use, port_b_line_three_use}, 16'h0002);
        unit_two_pin_select = 1'b0;
        @(negedge core_clk);
        check("b use", {14'h0000, port_c_line_one_use, port_b_line_three_use}, 16'h0001);
        wr(3'h4, 8'h08);
        wr(3'h6, 8'h00);
        wr(3'h5, 8'h00);
        @(negedge core_clk);
        check("b out", {14'h0000, port_c_line_one_out, port_b_line_three_out}, 16'h0003);
        unit_two_pin_select = 1'b1;
    endtask : t_pins

    task automatic t_pwm();
        wr(3'h1, 8'h04);
        wr(3'h5, 8'h04);
        wr(3'h0, 8'h0c);
        wr(3'h4, 8'h0c);
        for (int i = 0; i < 20 && timer_two_period !== 1'b1; i++)
            @(negedge core_clk);
        @(negedge core_clk);
        check("pwm high", {14'h0000, unit_one_out, port_c_line_one_out}, 16'h0003);
        for (int i = 0; i < 16; i++)
        begin
            check("pwm same", {15'h0000, port_c_line_one_out}, {15'h0000, unit_one_out});
            if (i == 5)
                check("pwm low", {15'h0000, unit_one_out}, 16'h0000);
            @(negedge core_clk);
        end
    endtask : t_pwm

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (8) @(negedge core_clk);
        reset_n = 1'b1;
        t_regs();
        t_capture();
        t_async();
        t_compare();
        t_pins();
        t_pwm();
        end_of_test();
    end

    // The run needs well under a thousand cycles; this cuts a hang short.
    initial
    begin
        #50000;
        n_mismatch++;
        end_of_test();
    end
endmodule : tb

bind ccr_timer_routing ccr_monitor mon_u (.core_clk, .reset_n, .unit_one_regs,
    .unit_two_regs, .timer_three_select, .timer_one_async, .unit_two_pin_select,
    .timer_two_period, .unit_one_out, .port_c_line_one_use, .port_b_line_three_use,
    .timer_one_reset, .timer_three_reset, .adc_start, .unit_event);
